//--- src/ses_pkg.sv
// package for the scale error supervisor: codes, offsets, timing counts, carriers
// assumes a 20 MHz core clock and a plain strobe register port
//
// Operation
// (RL1) any error forces outputs passive, analog zero
// (RL2) process-active output drops on error
// (RL3) code zero only when normal, no error
// (RL4) not normal state reports code three
// (RL5) enabled overload above upper limit reports four
// (RL6) signal above operating range reports five
// (RL7) enabled underload below lower limit reports six
// (RL8) signal below operating range reports seven
// (RL9) current over 220 mA: code nine, excitation off
// (RL10) retry excitation every 20 seconds while off
// (RL11) supervision limit crossed: warning ten, if enabled
// (RL12) sense voltage out of range reports eleven
// (RL13) transducer signal out of range reports twelve
// (RL14) settling after power-up or filter change: fourteen
// (RL15) readable instrument, command and scale error registers
// (RL16) weight error clears when cause disappears
// (RL17) version read as program, major, minor
// (RL18) program/hardware mismatch: fatal state, code 90
// (RL19) upgrade result lights green or red
// (RL20) converter hardware failure reports fifteen
// (RL21) weight needing over six digits reports twenty
// (RL22) several errors: most severe code wins
package ses_pkg;

  // scale error codes
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_NOTNORMAL = 8'h03;
  localparam logic [7:0] CODE_OVERLOAD  = 8'h04;
  localparam logic [7:0] CODE_OVERRANGE = 8'h05;
  localparam logic [7:0] CODE_UNDERLOAD = 8'h06;
  localparam logic [7:0] CODE_UNDERRNG  = 8'h07;
  localparam logic [7:0] CODE_EXCCRIT   = 8'h09;
  localparam logic [7:0] CODE_EXCWARN   = 8'h0a;
  localparam logic [7:0] CODE_SENSE     = 8'h0b;
  localparam logic [7:0] CODE_SIGNAL    = 8'h0c;
  localparam logic [7:0] CODE_SETTLING  = 8'h0e;
  localparam logic [7:0] CODE_ADCFAIL   = 8'h0f;
  localparam logic [7:0] CODE_DIGITS    = 8'h14;
  localparam logic [7:0] CODE_SWHW      = 8'h5a;

  // register offsets
  localparam logic [3:0] OFS_SCALE_ERR  = 4'h0;
  localparam logic [3:0] OFS_INSTR_ERR  = 4'h1;
  localparam logic [3:0] OFS_CMD_ERR    = 4'h2;
  localparam logic [3:0] OFS_CONTROL    = 4'h3;
  localparam logic [3:0] OFS_HI_LIMIT   = 4'h4;
  localparam logic [3:0] OFS_LO_LIMIT   = 4'h5;
  localparam logic [3:0] OFS_VERSION    = 4'h6;
  localparam logic [3:0] OFS_STATUS     = 4'h7;

  // control field positions
  localparam int CTL_OVLD_EN = 0;
  localparam int CTL_EXC_SUP = 1;
  localparam int CTL_FILTER  = 4;
  localparam int CTL_FILT_W  = 4;

  // reset values
  localparam logic [31:0] RST_CONTROL  = 32'h0000_0003;
  localparam logic [31:0] RST_HI_LIMIT = 32'h7fff_ffff;
  localparam logic [31:0] RST_LO_LIMIT = 32'h8000_0000;

  // timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int RETRY_SEC     = 20;
  localparam longint RETRY_CYC = longint'(RETRY_SEC) * longint'(CLK_HZ);
  localparam int EXC_CRIT_MA   = 220;

  // version fields; program number selects the model family
  localparam logic [7:0] PROG_STD = 8'h01;

  // condition flags from the measurement front end
  typedef struct packed {
    logic overRange;
    logic underRange;
    logic senseBad;
    logic signalBad;
    logic adcFail;
    logic excWarn;
  } ses_cond_t;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ses_bus_t;

  // safe-state controlled outputs
  typedef struct packed {
    logic [3:0]  digOut;
    logic [15:0] anaOut;
    logic        inProcess;
  } ses_out_t;

  // supervisor top states
  typedef enum logic [1:0] {
    ST_START  = 2'b00,
    ST_NORMAL = 2'b01,
    ST_FATAL  = 2'b10
  } ses_state_t;

endpackage : ses_pkg

//--- src/ses_exc_retry.sv
// excitation shutdown and periodic retry timer
// assumes overCurrent is already synchronised to core_clk
`timescale 1ns/100ps
`default_nettype none
module ses_exc_retry #(
  parameter longint RETRY_CYC = ses_pkg::RETRY_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstnSync,
  // current comparator
  input  wire logic overCurrent,
  // excitation control
  output logic      excOn,
  output logic      excCrit
);
  localparam int CW = 40;
  localparam logic [CW-1:0] LAST = CW'(RETRY_CYC - 1);

  logic [CW-1:0] cnt;           // retry timer while shut off
  logic [CW-1:0] next_cnt;
  logic          tripped;       // excitation held off
  logic          next_tripped;

  // trip on over-current, count up to the retry period, then test with excitation on
  always_comb begin
    next_tripped = tripped;
    next_cnt     = cnt;
    if (overCurrent && excOn) begin
      next_tripped = 1'b1;                      // see (RL9)
      next_cnt     = '0;
    end else if (tripped) begin
      if (cnt == LAST) begin
        next_tripped = 1'b0;                    // see (RL10)
        next_cnt     = '0;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cnt     <= '0;
      tripped <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      tripped <= next_tripped;
    end
  end

  // latch code stays up while excitation is off, clears once overCurrent is low with excitation back on
  logic critHold;
  logic next_critHold;
  always_comb begin
    next_critHold = critHold;
    if (overCurrent) next_critHold = 1'b1;
    else if (!tripped) next_critHold = 1'b0;
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) critHold <= 1'b0;
    else critHold <= next_critHold;
  end

  assign excOn   = !tripped;
  assign excCrit = critHold || tripped;         // see (RL9)

  a_trip_off: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (overCurrent && excOn) |=> !excOn) else $error("excitation not cut"); // see (RL9)
  cv_trip: cover property (@(posedge core_clk) disable iff (!rstnSync) $fell(excOn));
endmodule : ses_exc_retry
`default_nettype wire

//--- src/ses_supervisor.sv
// scale error supervisor top: code priority, safe outputs, register port
// assumes front-end condition pins are asynchronous; weight arrives from core logic
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ses_supervisor #(
  parameter longint   RETRY_CYC = ses_pkg::RETRY_CYC,
  parameter int       SETTLE_N  = 16,
  parameter int       MAX_DISP  = 999_999,
  parameter logic [7:0] HW_PROG = ses_pkg::PROG_STD,   // model family; arbitrary default
  parameter logic [7:0] VER_MAJ = 8'h01,               // arbitrary
  parameter logic [7:0] VER_MIN = 8'h00                // arbitrary
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // front-end conditions (asynchronous pins)
  input  wire ses_pkg::ses_cond_t condPin,
  input  wire logic              overCurrentPin,
  // weight path, core clock
  input  wire logic signed [31:0] weight,
  input  wire logic              convDone,
  input  wire logic [31:0]       dispMag,
  // program identity and upgrade result
  input  wire logic [7:0]        progNum,
  input  wire logic              upgDone,
  input  wire logic              upgOk,
  // normal-operation outputs from the application
  input  wire ses_pkg::ses_out_t appOut,
  // register port
  input  wire ses_pkg::ses_bus_t bus,
  output logic [31:0]            rdata,
  // controlled outputs
  output ses_pkg::ses_out_t      safeOut,
  output logic                   excEnable,
  output logic                   ledGreen,
  output logic                   ledRed
);
  localparam int NC = 7;

  // reset release
  logic [1:0] rstSync;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rstSync <= 2'b00;
    else rstSync <= {rstSync[0], 1'b1};
  end
  logic rstnSync;
  assign rstnSync = rstSync[1];

  // three-stage pin synchroniser; change taken when stages two and three agree
  logic [NC-1:0] s1, s2, s3, cond;
  logic [NC-1:0] pinVec;
  logic [NC-1:0] next_cond;
  assign pinVec = {overCurrentPin, condPin};
  always_comb begin
    next_cond = cond;
    for (int i = 0; i < NC; i++) begin
      if (s2[i] == s3[i]) next_cond[i] = s3[i];
    end
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      cond <= '0;
    end else begin
      s1   <= pinVec;
      s2   <= s1;
      s3   <= s2;
      cond <= next_cond;
    end
  end
  ses_pkg::ses_cond_t c;
  logic overCur;
  assign c       = cond[NC-2:0];
  assign overCur = cond[NC-1];

  // excitation protection
  logic excCrit;
  ses_exc_retry #(.RETRY_CYC(RETRY_CYC)) u_exc (
    .core_clk    (core_clk),
    .rstnSync    (rstnSync),
    .overCurrent (overCur),
    .excOn       (excEnable),
    .excCrit     (excCrit)
  );

  // software registers
  logic [31:0] control, next_control;
  logic [31:0] hiLimit, next_hiLimit;
  logic [31:0] loLimit, next_loLimit;
  logic [7:0]  cmdErr,  next_cmdErr;
  logic        filtChg;                      // filter field written with new value
  always_comb begin
    next_control = control;
    next_hiLimit = hiLimit;
    next_loLimit = loLimit;
    next_cmdErr  = cmdErr;
    filtChg      = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        ses_pkg::OFS_CONTROL: begin
          next_control = bus.wdata;
          filtChg = bus.wdata[ses_pkg::CTL_FILTER +: ses_pkg::CTL_FILT_W] !=
                    control[ses_pkg::CTL_FILTER +: ses_pkg::CTL_FILT_W];
        end
        ses_pkg::OFS_HI_LIMIT: next_hiLimit = bus.wdata;
        ses_pkg::OFS_LO_LIMIT: next_loLimit = bus.wdata;
        ses_pkg::OFS_CMD_ERR:  next_cmdErr  = bus.wdata[7:0];  // write sets, zero clears
        default: next_cmdErr = 8'h01;                          // write to read-only or unmapped address
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      control <= ses_pkg::RST_CONTROL;
      hiLimit <= ses_pkg::RST_HI_LIMIT;
      loLimit <= ses_pkg::RST_LO_LIMIT;
      cmdErr  <= 8'h00;
    end else begin
      control <= next_control;
      hiLimit <= next_hiLimit;
      loLimit <= next_loLimit;
      cmdErr  <= next_cmdErr;
    end
  end

  // settling counter: conversions needed after power-up or filter change
  localparam int SW = $clog2(SETTLE_N + 1);
  logic [SW-1:0] settle, next_settle;
  logic settled;
  assign settled = (settle == SW'(SETTLE_N));
  always_comb begin
    next_settle = settle;
    if (filtChg) next_settle = '0;                         // see (RL14)
    else if (convDone && !settled) next_settle = settle + SW'(1);
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) settle <= '0;
    else settle <= next_settle;
  end

  // top state: program check once after reset release, fatal is sticky
  ses_pkg::ses_state_t state, next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ses_pkg::ST_START:  next_state = (progNum == HW_PROG) ? ses_pkg::ST_NORMAL
                                                            : ses_pkg::ST_FATAL; // see (RL18)
      ses_pkg::ST_NORMAL: next_state = ses_pkg::ST_NORMAL;
      ses_pkg::ST_FATAL:  next_state = ses_pkg::ST_FATAL;
      default:            next_state = ses_pkg::ST_FATAL;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) state <= ses_pkg::ST_START;
    else state <= next_state;
  end

  // scale error code, most severe first; recomputed each cycle so it clears
  logic [7:0] scaleCode, next_scaleCode;
  logic ovl, unl;
  assign ovl = control[ses_pkg::CTL_OVLD_EN] && (weight > $signed(hiLimit));
  assign unl = control[ses_pkg::CTL_OVLD_EN] && (weight < $signed(loLimit));
  always_comb begin
    if (state != ses_pkg::ST_NORMAL)           next_scaleCode = ses_pkg::CODE_NOTNORMAL; // see (RL4)
    else if (c.adcFail)                        next_scaleCode = ses_pkg::CODE_ADCFAIL;   // see (RL20)
    else if (excCrit)                          next_scaleCode = ses_pkg::CODE_EXCCRIT;   // see (RL9)
    else if (c.signalBad)                      next_scaleCode = ses_pkg::CODE_SIGNAL;    // see (RL13)
    else if (c.senseBad)                       next_scaleCode = ses_pkg::CODE_SENSE;     // see (RL12)
    else if (!settled)                         next_scaleCode = ses_pkg::CODE_SETTLING;  // see (RL14)
    else if (c.overRange)                      next_scaleCode = ses_pkg::CODE_OVERRANGE; // see (RL6)
    else if (c.underRange)                     next_scaleCode = ses_pkg::CODE_UNDERRNG;  // see (RL8)
    else if (ovl)                              next_scaleCode = ses_pkg::CODE_OVERLOAD;  // see (RL5)
    else if (unl)                              next_scaleCode = ses_pkg::CODE_UNDERLOAD; // see (RL7)
    else if (dispMag > 32'(MAX_DISP))          next_scaleCode = ses_pkg::CODE_DIGITS;    // see (RL21)
    else if (c.excWarn && control[ses_pkg::CTL_EXC_SUP])
                                               next_scaleCode = ses_pkg::CODE_EXCWARN;   // see (RL11)
    else                                       next_scaleCode = ses_pkg::CODE_NONE;      // see (RL3)
  end                                                                                    // see (RL22)
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) scaleCode <= ses_pkg::CODE_NOTNORMAL;
    else scaleCode <= next_scaleCode;                                                    // see (RL16)
  end

  // instrument error: fatal start-up code
  logic [7:0] instrErr;
  assign instrErr = (state == ses_pkg::ST_FATAL) ? ses_pkg::CODE_SWHW : 8'h00;   // see (RL18)

  // warning keeps the unit running, every other nonzero code forces the safe state
  logic errAct;
  assign errAct = (scaleCode != ses_pkg::CODE_NONE) && (scaleCode != ses_pkg::CODE_EXCWARN);

  // safe outputs registered so glitches in the code never reach pins
  ses_pkg::ses_out_t next_out;
  always_comb begin
    next_out = appOut;
    if (errAct || next_scaleCode != ses_pkg::CODE_NONE &&
        next_scaleCode != ses_pkg::CODE_EXCWARN) begin
      next_out.digOut    = 4'h0;                   // see (RL1)
      next_out.anaOut    = 16'h0000;               // see (RL1)
      next_out.inProcess = 1'b0;                   // see (RL2)
    end
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) safeOut <= '0;
    else safeOut <= next_out;
  end

  // upgrade indicators, caught once at completion
  logic next_green, next_red;
  always_comb begin
    next_green = ledGreen;
    next_red   = ledRed;
    if (upgDone) begin
      next_green = upgOk;                          // see (RL19)
      next_red   = !upgOk;                         // see (RL19)
    end
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ledGreen <= 1'b0;
      ledRed   <= 1'b0;
    end else begin
      ledGreen <= next_green;
      ledRed   <= next_red;
    end
  end

  // read port, data one cycle after the strobe, zero otherwise
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      unique case (bus.addr)
        ses_pkg::OFS_SCALE_ERR: next_rdata = {24'h0, scaleCode};           // see (RL15)
        ses_pkg::OFS_INSTR_ERR: next_rdata = {24'h0, instrErr};            // see (RL15)
        ses_pkg::OFS_CMD_ERR:   next_rdata = {24'h0, cmdErr};              // see (RL15)
        ses_pkg::OFS_CONTROL:   next_rdata = control;
        ses_pkg::OFS_HI_LIMIT:  next_rdata = hiLimit;
        ses_pkg::OFS_LO_LIMIT:  next_rdata = loLimit;
        ses_pkg::OFS_VERSION:   next_rdata = {8'h0, progNum, VER_MAJ, VER_MIN}; // see (RL17)
        ses_pkg::OFS_STATUS:    next_rdata = {28'h0, excEnable, settled, errAct,
                                              state == ses_pkg::ST_NORMAL};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstnSync) begin
    if (!rstnSync) rdata <= '0;
    else rdata <= next_rdata;
  end

  // checks
  a_safe_digout: assert property (@(posedge core_clk) disable iff (!rstnSync)
    errAct |-> (safeOut.digOut == 4'h0 && safeOut.anaOut == 16'h0000))
    else $error("outputs not safe under error"); // see (RL1)
  a_inproc_drop: assert property (@(posedge core_clk) disable iff (!rstnSync)
    errAct |-> !safeOut.inProcess) else $error("in-process high under error"); // see (RL2)
  a_zero_code: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (scaleCode == ses_pkg::CODE_NONE) |-> $past(state == ses_pkg::ST_NORMAL && settled))
    else $error("zero code while not normal"); // see (RL3)
  a_not_normal: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (state != ses_pkg::ST_NORMAL) |=> (scaleCode == ses_pkg::CODE_NOTNORMAL))
    else $error("code three missing"); // see (RL4)
  a_fatal_code: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (state == ses_pkg::ST_START && progNum != HW_PROG) |=> (instrErr == ses_pkg::CODE_SWHW)[*3])
    else $error("mismatch not fatal"); // see (RL18)
  a_settle_rst: assert property (@(posedge core_clk) disable iff (!rstnSync)
    filtChg |=> !settled) else $error("filter change did not restart settling"); // see (RL14)
  a_read_data: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (bus.rd && bus.addr == ses_pkg::OFS_SCALE_ERR) |=> (rdata[7:0] == $past(scaleCode)))
    else $error("scale code read wrong"); // see (RL15)
  a_led_result: assert property (@(posedge core_clk) disable iff (!rstnSync)
    upgDone |=> (ledGreen == $past(upgOk) && ledRed != ledGreen))
    else $error("upgrade led wrong"); // see (RL19)
  a_crit_code: assert property (@(posedge core_clk) disable iff (!rstnSync)
    (!excEnable && state == ses_pkg::ST_NORMAL && !c.adcFail) |=> scaleCode == ses_pkg::CODE_EXCCRIT)
    else $error("critical code missing"); // see (RL9)
  cv_clean:   cover property (@(posedge core_clk) disable iff (!rstnSync)
    $rose(scaleCode == ses_pkg::CODE_NONE));
  cv_ovl:     cover property (@(posedge core_clk) disable iff (!rstnSync)
    scaleCode == ses_pkg::CODE_OVERLOAD ##1 scaleCode == ses_pkg::CODE_NONE);
  cv_fatal:   cover property (@(posedge core_clk) disable iff (!rstnSync)
    state == ses_pkg::ST_FATAL);
endmodule : ses_supervisor
`default_nettype wire

//--- tb/ses_cell_model.sv
// load cell front end model: fault levels and excitation current sense
// assumes the bench chooses the faults; current flows only while excitation is on
`timescale 1ns/100ps
`default_nettype none
module ses_cell_model (
  // fault selection from the bench
  input  wire ses_pkg::ses_cond_t faults,
  input  wire logic               shorted,
  // excitation from the supervisor
  input  wire logic               excEnable,
  // pins toward the supervisor
  output ses_pkg::ses_cond_t      condPin,
  output logic                    overCurrentPin
);
  // a short draws current only while the bridge is excited, so the retry sees it again
  assign overCurrentPin = shorted & excEnable;
  // with excitation cut the sense lines collapse, which a real bridge would show too
  always_comb begin
    condPin          = faults;
    condPin.senseBad = faults.senseBad | ~excEnable;
  end
endmodule : ses_cell_model
`default_nettype wire

//--- tb/tb_ses_supervisor.sv
// bench for the scale error supervisor: register tasks and code sequences
// assumes the cell model on the pins and shortened retry and settle counts
`timescale 1ns/100ps
`default_nettype none
module tb_ses_supervisor;
  localparam int RC = 50;  // shortened retry period
  localparam int SN = 4;   // shortened settle count
  logic               core_clk = 1'b0;
  logic               rstn     = 1'b0;
  ses_pkg::ses_cond_t faults   = '0;
  logic               shorted  = 1'b0;
  ses_pkg::ses_cond_t condPin;
  logic               overCurrentPin;
  logic signed [31:0] weight   = '0;
  logic               convDone = 1'b0;
  logic [31:0]        dispMag  = '0;
  logic [7:0]         progNum  = 8'h01;
  logic               upgDone  = 1'b0;
  logic               upgOk    = 1'b0;
  ses_pkg::ses_out_t  appOut   = '{digOut: 4'hf, anaOut: 16'h1234, inProcess: 1'b1};
  ses_pkg::ses_bus_t  bus      = '0;
  logic [31:0]        rdata;
  ses_pkg::ses_out_t  safeOut;
  logic               excEnable, ledGreen, ledRed;
  int                 n_mismatch = 0;
  int                 n_checks   = 0;
  int                 cyc        = 0;
  // code expected for each condition bit, lowest bit first
  logic [7:0] condCode [6] = '{ses_pkg::CODE_EXCWARN, ses_pkg::CODE_ADCFAIL,
    ses_pkg::CODE_SIGNAL, ses_pkg::CODE_SENSE, ses_pkg::CODE_UNDERRNG, ses_pkg::CODE_OVERRANGE};

  ses_supervisor #(.RETRY_CYC(RC), .SETTLE_N(SN)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .condPin(condPin), .overCurrentPin(overCurrentPin),
    .weight(weight), .convDone(convDone), .dispMag(dispMag), .progNum(progNum),
    .upgDone(upgDone), .upgOk(upgOk), .appOut(appOut), .bus(bus), .rdata(rdata),
    .safeOut(safeOut), .excEnable(excEnable), .ledGreen(ledGreen), .ledRed(ledRed));
  ses_cell_model i_cell (.faults(faults), .shorted(shorted), .excEnable(excEnable),
    .condPin(condPin), .overCurrentPin(overCurrentPin));

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // hang guard; the whole sequence needs well under this
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, rdata);
    @(posedge core_clk);  // later stimulus then lands on a rising edge
  endtask : rd

  task automatic code(input logic [7:0] c);
    rd(ses_pkg::OFS_SCALE_ERR, {24'h0, c}, "scale code");
  endtask : code

  task automatic conv(input int n);
    repeat (n) begin
      @(posedge core_clk);
      convDone <= 1'b1;
      @(posedge core_clk);
      convDone <= 1'b0;
    end
  endtask : conv

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    int n;
    tick(10);
    rstn <= 1'b1;
    tick(4);
    rd(ses_pkg::OFS_CONTROL, ses_pkg::RST_CONTROL, "control");
    rd(ses_pkg::OFS_HI_LIMIT, ses_pkg::RST_HI_LIMIT, "upper limit");
    rd(ses_pkg::OFS_LO_LIMIT, ses_pkg::RST_LO_LIMIT, "lower limit");
    code(ses_pkg::CODE_SETTLING);
    chk("safe out", 32'h0, 32'(safeOut));
    chk("in process", 32'h0, 32'(safeOut.inProcess));
    conv(SN);
    code(ses_pkg::CODE_NONE);
    chk("safe out", 32'(appOut), 32'(safeOut));
    // each front-end condition alone, then gone again
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      faults <= ses_pkg::ses_cond_t'(6'h01 << i);
      tick(10);
      code(condCode[i]);
      chk("safe out", (i == 0) ? 32'(appOut) : 32'h0, 32'(safeOut));
      @(posedge core_clk);
      faults <= '0;
      tick(10);
      code(ses_pkg::CODE_NONE);
    end
    // warning skipped while supervision is off
    wr(ses_pkg::OFS_CONTROL, 32'h1);
    faults <= 6'h01;
    tick(10);
    code(ses_pkg::CODE_NONE);
    wr(ses_pkg::OFS_CONTROL, 32'h3);
    faults <= 6'h28;
    tick(10);
    code(ses_pkg::CODE_SENSE);
    faults <= '0;
    // weight limits, equal to the limit is still fine
    wr(ses_pkg::OFS_HI_LIMIT, 32'd100);
    wr(ses_pkg::OFS_LO_LIMIT, 32'hffff_ff9c);
    weight <= 32'sd100;
    tick(10);
    code(ses_pkg::CODE_NONE);
    weight <= 32'sd101;
    code(ses_pkg::CODE_OVERLOAD);
    weight <= -32'sd200;
    code(ses_pkg::CODE_UNDERLOAD);
    wr(ses_pkg::OFS_CONTROL, 32'h2);
    code(ses_pkg::CODE_NONE);
    wr(ses_pkg::OFS_CONTROL, 32'h3);
    weight <= '0;
    dispMag <= 32'd1_000_000;
    tick(2);
    code(ses_pkg::CODE_DIGITS);
    dispMag <= 32'd999_999;
    tick(2);
    code(ses_pkg::CODE_NONE);
    // filter change restarts settling
    wr(ses_pkg::OFS_CONTROL, 32'h13);
    code(ses_pkg::CODE_SETTLING);
    conv(SN - 1);
    code(ses_pkg::CODE_SETTLING);
    conv(1);
    code(ses_pkg::CODE_NONE);
    // short on the excitation: cut, retry, cut again, then recover
    shorted <= 1'b1;
    n = 0;
    while (excEnable !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    code(ses_pkg::CODE_EXCCRIT);
    chk("excitation", 32'h0, 32'(excEnable));
    n = 0;
    while (excEnable !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    n_checks++;
    if (n < RC - 8 || n > RC + 3) begin
      n_mismatch++;
      $display("Error retry period expected %0d seen %0d", RC, n);
    end
    tick(10);
    chk("excitation", 32'h0, 32'(excEnable));
    shorted <= 1'b0;
    tick(RC + 20);
    code(ses_pkg::CODE_NONE);
    chk("excitation", 32'h1, 32'(excEnable));
    // register map
    rd(ses_pkg::OFS_VERSION, 32'h0001_0100, "version");
    rd(ses_pkg::OFS_INSTR_ERR, 32'h0, "instrument error");
    wr(ses_pkg::OFS_SCALE_ERR, 32'h5);
    code(ses_pkg::CODE_NONE);
    rd(ses_pkg::OFS_CMD_ERR, 32'h1, "command error");
    rd(4'h8, 32'h0, "unmapped");
    // upgrade result lamps
    for (int k = 1; k >= 0; k--) begin
      @(posedge core_clk);
      upgDone <= 1'b1;
      upgOk   <= k[0];
      @(posedge core_clk);
      upgDone <= 1'b0;
      @(negedge core_clk);
      chk("green", 32'(k[0]), 32'(ledGreen));
      chk("red", 32'(!k[0]), 32'(ledRed));
    end
    // program for another family
    @(posedge core_clk);
    rstn    <= 1'b0;
    progNum <= 8'h03;
    tick(10);
    rstn <= 1'b1;
    tick(6);
    conv(SN);
    code(ses_pkg::CODE_NOTNORMAL);
    rd(ses_pkg::OFS_INSTR_ERR, {24'h0, ses_pkg::CODE_SWHW}, "instrument error");
    chk("safe out", 32'h0, 32'(safeOut));
    rd(ses_pkg::OFS_STATUS, 32'he, "status");
    complete_run();
  end
endmodule : tb_ses_supervisor
`default_nettype wire
